// [include/mtpcs_map.svh]
// constants for the multiple-time-programmable memory host sequencer
`ifndef MTPCS_MAP_SVH
`define MTPCS_MAP_SVH
`define MTPCS_CMD_READ 8'h00
`define MTPCS_CMD_ERASE 8'h20
`define MTPCS_CMD_SETUP_PROG 8'h40
`define MTPCS_CMD_ERASE_VERIFY 8'hA0
`define MTPCS_CMD_RESET 8'hFF
`define MTPCS_ERASED_BYTE 8'hFF
`define MTPCS_ADDR_W 18
`define MTPCS_MAX_PROG_PULSES 25
`define MTPCS_MAX_ERASE_PULSES 30
`define MTPCS_CLK_NS 5
`define MTPCS_PROG_PULSE_NS 10000
`define MTPCS_ERASE_PULSE_MS 100
`define MTPCS_PROG_PULSE_CYC (`MTPCS_PROG_PULSE_NS / `MTPCS_CLK_NS)
`define MTPCS_ERASE_PULSE_CYC (`MTPCS_ERASE_PULSE_MS * 1000000 / `MTPCS_CLK_NS)
`define MTPCS_STROBE_CYC 4
`define MTPCS_SETTLE_CYC 4
`define MTPCS_ID_ADDR 18'h00200
`endif

// [include/mtpcs_pkg.sv]
// types for the memory host sequencer
package mtpcs_pkg;
    typedef enum logic [2:0] {
        MTPCS_OP_READ,
        MTPCS_OP_PROGRAM,
        MTPCS_OP_ERASE,
        MTPCS_OP_IDENT,
        MTPCS_OP_RESET
    } mtpcs_op_type;
    typedef enum logic [1:0] {
        MTPCS_CYC_WRITE,
        MTPCS_CYC_READ
    } mtpcs_cyc_type;
endpackage

// [include/mtpcs_bus_if.sv]
// request/answer bundle between sequencer and its pin cycle engine
`timescale 1ns/1ps
interface mtpcs_bus_if;
    import mtpcs_pkg::*;
    logic req;
    logic done;
    mtpcs_cyc_type kind;
    logic [17:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic idHigh;
    modport seq (output req, kind, addr, wdata, idHigh, input done, rdata);
    modport eng (input req, kind, addr, wdata, idHigh, output done, rdata);
endinterface

// [src/mtpcs_pin_cycle.sv]
// pin cycle engine: one write strobe or one read cycle per request
`timescale 1ns/1ps
`include "mtpcs_map.svh"
module mtpcs_pin_cycle
    import mtpcs_pkg::*;
(
    input wire logic sys_clk, // clock
    input wire logic resetn, // sync reset
    mtpcs_bus_if.eng bus, // cycle requests
    output logic chipSelN_q, // chip select, low active
    output logic outGateN_q, // output gate, low active
    output logic writeStrobeN_q, // write strobe, low active
    output logic [17:0] locationLines_q, // address pins
    output logic [7:0] byteLinesOut_q, // data driven
    output logic byteLinesOe_q, // data drive enable
    input wire logic [7:0] byteLinesIn, // data sampled
    output logic identifyHigh_q // trigger line at identify voltage
);
    typedef enum {IDLE, SETUP, STROBE, HOLD, RDWAIT, FIN} pc_st_type;
    pc_st_type st_q;
    logic [3:0] cnt_q;
    logic [7:0] rdata_q;

    assign bus.done = (st_q == FIN);
    assign bus.rdata = rdata_q;

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            st_q <= IDLE;
            cnt_q <= 4'h0;
        end else begin
            case (st_q)
                IDLE: if (bus.req) begin
                    st_q <= SETUP;
                    cnt_q <= 4'h0;
                end
                SETUP: begin
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q == 4'(`MTPCS_SETTLE_CYC - 1)) begin
                        cnt_q <= 4'h0;
                        st_q <= (bus.kind == MTPCS_CYC_WRITE) ? STROBE : RDWAIT;
                    end
                end
                STROBE: begin
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q == 4'(`MTPCS_STROBE_CYC - 1)) begin
                        cnt_q <= 4'h0;
                        st_q <= HOLD;
                    end
                end
                HOLD: st_q <= FIN;
                RDWAIT: begin
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q == 4'(`MTPCS_SETTLE_CYC - 1)) begin
                        st_q <= FIN;
                    end
                end
                FIN: st_q <= IDLE;
                default: st_q <= IDLE;
            endcase
        end
    end

    // pins; address settles before strobe falls, data held past its rise
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            chipSelN_q <= 1'b1;
            outGateN_q <= 1'b1;
            writeStrobeN_q <= 1'b1;
            locationLines_q <= 18'h00000;
            byteLinesOut_q <= 8'h00;
            byteLinesOe_q <= 1'b0;
            identifyHigh_q <= 1'b0;
        end else begin
            if (st_q == IDLE && bus.req) begin
                chipSelN_q <= 1'b0;
                locationLines_q <= bus.addr;
                identifyHigh_q <= bus.idHigh;
                byteLinesOut_q <= bus.wdata;
                byteLinesOe_q <= (bus.kind == MTPCS_CYC_WRITE);
                outGateN_q <= (bus.kind == MTPCS_CYC_WRITE);
            end
            writeStrobeN_q <= !(st_q == STROBE);
            if (st_q == FIN) begin
                chipSelN_q <= 1'b1;
                outGateN_q <= 1'b1;
                byteLinesOe_q <= 1'b0;
                identifyHigh_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            rdata_q <= 8'h00;
        end else if (st_q == RDWAIT && cnt_q == 4'(`MTPCS_SETTLE_CYC - 1)) begin
            rdata_q <= byteLinesIn;
        end
    end

    property p_strobe_len;
        @(posedge sys_clk) disable iff (!resetn)
        $fell(writeStrobeN_q) |-> !writeStrobeN_q [*4] ##1 writeStrobeN_q;
    endproperty
    a_strobe_len: assert property (p_strobe_len) else $error("strobe width wrong");

    property p_read_gate;
        @(posedge sys_clk) disable iff (!resetn)
        (st_q == RDWAIT) |-> (!outGateN_q && !chipSelN_q && writeStrobeN_q && !byteLinesOe_q);
    endproperty
    a_read_gate: assert property (p_read_gate) else $error("read pins wrong");
endmodule // mtpcs_pin_cycle

// [src/mtpcs_host.sv]
// host sequencer that programs, erases, identifies and resets the memory
`timescale 1ns/1ps
`include "mtpcs_map.svh"
module mtpcs_host
    import mtpcs_pkg::*;
#(
    parameter int PROG_PULSE_CYC = `MTPCS_PROG_PULSE_CYC,
    parameter int ERASE_PULSE_CYC = `MTPCS_ERASE_PULSE_CYC,
    parameter int MAX_PROG = `MTPCS_MAX_PROG_PULSES,
    parameter int MAX_ERASE = `MTPCS_MAX_ERASE_PULSES,
    parameter logic [17:0] LAST_ADDR = 18'h3FFFF
) (
    input wire logic sys_clk, // clock
    input wire logic resetn, // sync reset, low active
    input wire logic opValid, // start an operation
    input wire mtpcs_op_type opKind, // operation
    input wire logic [17:0] opAddr, // byte address
    input wire logic [7:0] opData, // program data
    input wire logic opIdSel, // identify: 0 maker, 1 device code
    output logic opReady, // idle, may start
    output logic opDone_q, // one-cycle completion pulse
    output logic opFail_q, // completion with failure
    output logic [7:0] opRdata_q, // read or identifier byte
    output logic progSupplyHigh_q, // raise program supply
    output logic chipSelN_q, // chip select, low active
    output logic outGateN_q, // output gate, low active
    output logic writeStrobeN_q, // write strobe, low active
    output logic [17:0] locationLines_q, // address pins
    output logic [7:0] byteLinesOut_q, // data out
    output logic byteLinesOe_q, // data drive enable
    input wire logic [7:0] byteLinesIn, // data in
    output logic identifyHigh_q // identify voltage on trigger line
);
    typedef enum {IDLE, W1, W2, PULSE, VFY_W, VFY_R, CHECK, RD, FINISH} seq_st_type;
    seq_st_type st_q;
    mtpcs_op_type op_q;
    logic [7:0] data_q;
    logic [17:0] addr_q;
    logic idSel_q;
    logic [5:0] pulses_q;
    logic [31:0] timer_q;
    logic [1:0] step_q;
    logic req;
    mtpcs_cyc_type kind;
    logic [17:0] addr;
    logic [7:0] wdata;
    logic idHi;
    logic ok;

    mtpcs_bus_if bus ();
    assign bus.req = req;
    assign bus.kind = kind;
    assign bus.addr = addr;
    assign bus.wdata = wdata;
    assign bus.idHigh = idHi;

    mtpcs_pin_cycle u_pins (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .bus(bus.eng),
        .chipSelN_q(chipSelN_q),
        .outGateN_q(outGateN_q),
        .writeStrobeN_q(writeStrobeN_q),
        .locationLines_q(locationLines_q),
        .byteLinesOut_q(byteLinesOut_q),
        .byteLinesOe_q(byteLinesOe_q),
        .byteLinesIn(byteLinesIn),
        .identifyHigh_q(identifyHigh_q)
    );

    assign opReady = (st_q == IDLE);

    // ----------------------------------------
    // pin cycle request selection
    // ----------------------------------------
    always_comb begin
        req = 1'b0;
        kind = MTPCS_CYC_WRITE;
        addr = addr_q;
        wdata = `MTPCS_CMD_RESET;
        idHi = 1'b0;
        case (st_q)
            W1: begin
                req = 1'b1;
                case (op_q)
                    MTPCS_OP_PROGRAM: wdata = `MTPCS_CMD_SETUP_PROG;
                    MTPCS_OP_ERASE: wdata = `MTPCS_CMD_ERASE;
                    MTPCS_OP_READ: wdata = `MTPCS_CMD_READ;
                    default: wdata = `MTPCS_CMD_RESET;
                endcase
            end
            W2: begin
                req = 1'b1;
                case (op_q)
                    MTPCS_OP_PROGRAM: wdata = data_q;
                    MTPCS_OP_ERASE: wdata = `MTPCS_CMD_ERASE;
                    default: wdata = `MTPCS_CMD_RESET;
                endcase
            end
            VFY_W: begin
                req = 1'b1;
                wdata = (op_q == MTPCS_OP_ERASE) ? `MTPCS_CMD_ERASE_VERIFY : `MTPCS_CMD_READ;
            end
            VFY_R, RD: begin
                req = 1'b1;
                kind = MTPCS_CYC_READ;
                if (op_q == MTPCS_OP_IDENT) begin
                    addr = {17'h00000, idSel_q};
                    idHi = 1'b1;
                end
            end
            default: req = 1'b0;
        endcase
    end

    // erase expects ones; program expects cleared bits to stay cleared
    // ones in the program data leave a bit as found, so only the bits to clear are checked
    assign ok = (op_q == MTPCS_OP_ERASE) ? (bus.rdata == `MTPCS_ERASED_BYTE) : ((bus.rdata & ~data_q) == 8'h00);

    // ----------------------------------------
    // operation sequencing
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            st_q <= IDLE;
            op_q <= MTPCS_OP_READ;
            data_q <= 8'h00;
            addr_q <= 18'h00000;
            idSel_q <= 1'b0;
            pulses_q <= 6'h00;
            timer_q <= 32'h0;
            step_q <= 2'h0;
            opDone_q <= 1'b0;
            opFail_q <= 1'b0;
            opRdata_q <= 8'h00;
        end else begin
            opDone_q <= 1'b0;
            case (st_q)
                IDLE: if (opValid) begin
                    op_q <= opKind;
                    data_q <= opData;
                    addr_q <= (opKind == MTPCS_OP_ERASE) ? 18'h00000 : opAddr;
                    idSel_q <= opIdSel;
                    pulses_q <= 6'h00;
                    opFail_q <= 1'b0;
                    st_q <= (opKind == MTPCS_OP_IDENT) ? RD : W1;
                end
                W1: if (bus.done) begin
                    st_q <= (op_q == MTPCS_OP_READ) ? RD : W2;
                end
                W2: if (bus.done) begin
                    if (op_q == MTPCS_OP_RESET) begin
                        st_q <= FINISH;
                    end else begin
                        pulses_q <= pulses_q + 6'h01;
                        timer_q <= 32'h0;
                        st_q <= PULSE;
                    end
                end
                PULSE: begin
                    // pulse runs until the next rising strobe ends it
                    timer_q <= timer_q + 32'h1;
                    if (timer_q == 32'((op_q == MTPCS_OP_ERASE) ? ERASE_PULSE_CYC - 1 : PROG_PULSE_CYC - 1)) begin
                        st_q <= VFY_W;
                    end
                end
                VFY_W: if (bus.done) st_q <= VFY_R;
                VFY_R: if (bus.done) begin
                    opRdata_q <= bus.rdata;
                    st_q <= CHECK;
                end
                CHECK: begin
                    if (ok && op_q == MTPCS_OP_PROGRAM) begin
                        st_q <= FINISH;
                    end else if (ok && addr_q == LAST_ADDR) begin
                        st_q <= FINISH;
                    end else if (ok) begin
                        addr_q <= addr_q + 18'h00001;
                        st_q <= VFY_W;
                    end else if (pulses_q == 6'(op_q == MTPCS_OP_ERASE ? MAX_ERASE : MAX_PROG)) begin
                        opFail_q <= 1'b1;
                        st_q <= FINISH;
                    end else begin
                        // failing address kept, verify resumes there
                        st_q <= W1;
                    end
                end
                RD: if (bus.done) begin
                    opRdata_q <= bus.rdata;
                    st_q <= FINISH;
                end
                FINISH: begin
                    opDone_q <= 1'b1;
                    st_q <= IDLE;
                end
                default: st_q <= IDLE;
            endcase
        end
    end

    // program supply high for every operation needing commands
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            progSupplyHigh_q <= 1'b0;
        end else begin
            progSupplyHigh_q <= (st_q != IDLE) && (op_q != MTPCS_OP_IDENT || st_q == W1);
        end
    end

    property p_prog_limit;
        @(posedge sys_clk) disable iff (!resetn)
        (op_q == MTPCS_OP_PROGRAM) |-> (pulses_q <= 6'(MAX_PROG));
    endproperty
    a_prog_limit: assert property (p_prog_limit) else $error("too many program pulses");

    property p_erase_limit;
        @(posedge sys_clk) disable iff (!resetn)
        (op_q == MTPCS_OP_ERASE) |-> (pulses_q <= 6'(MAX_ERASE));
    endproperty
    a_erase_limit: assert property (p_erase_limit) else $error("too many erase pulses");

    sequence s_pulse_end;
        (st_q == PULSE) ##1 (st_q == VFY_W);
    endsequence
    property p_verify_after;
        @(posedge sys_clk) disable iff (!resetn)
        s_pulse_end |-> (st_q == VFY_W) [*1] ##[1:40] (st_q == VFY_R);
    endproperty
    a_verify_after: assert property (p_verify_after) else $error("no verify after pulse");

    property p_supply_cmd;
        @(posedge sys_clk) disable iff (!resetn)
        $fell(writeStrobeN_q) |-> progSupplyHigh_q;
    endproperty
    a_supply_cmd: assert property (p_supply_cmd) else $error("write without high supply");

    property p_reset_twice;
        @(posedge sys_clk) disable iff (!resetn)
        (st_q == W2 && op_q == MTPCS_OP_RESET && bus.done) |=> (st_q == FINISH) ##1 opDone_q;
    endproperty
    a_reset_twice: assert property (p_reset_twice) else $error("reset pair wrong");

    property p_ident_addr;
        @(posedge sys_clk) disable iff (!resetn)
        identifyHigh_q |-> (locationLines_q[17:1] == 17'h00000);
    endproperty
    a_ident_addr: assert property (p_ident_addr) else $error("identify address lines high");
endmodule // mtpcs_host

// [verification/mtpcs_mem_model.sv]
// behavioural model of the memory device behind the host sequencer
`timescale 1ns/1ps
module mtpcs_mem_model #(
    parameter logic [7:0] MAKER_CODE = 8'h01, // arbitrary value, odd parity
    parameter logic [7:0] DEVICE_CODE = 8'h83, // arbitrary value, odd parity
    parameter int STUCK = 3
) (
    input wire logic chipSelN, // select
    input wire logic outGateN, // gate
    input wire logic writeStrobeN, // strobe
    input wire logic [17:0] locationLines, // address
    input wire logic progSupplyHigh, // supply
    input wire logic mainSupplyOk, // main supply above lockout
    input wire logic identifyHigh, // id voltage
    input wire logic [7:0] busIn, // data lines
    input wire logic [7:0] progResist, // dead pulses
    input wire logic [7:0] eraseResist, // dead pulses
    output logic [7:0] busOut, // read drive
    output int progPulses, // pulse count
    output int erasePulses, // pulse count
    output logic seqError, // host misstep
    output logic inRead // read mode
);
    typedef enum logic [2:0] {M_READ, M_SPROG, M_PROG, M_SERASE, M_ERASE, M_EVER} mtpcs_mst_type;
    mtpcs_mst_type st = M_READ;
    logic [7:0] mem [16];
    logic [17:0] latAddr, pAddr, vAddr;
    logic [7:0] pData, readVal;
    logic needVerify = 1'b0;
    int progRun = 0;
    int eraseRun = 0;

    initial begin
        foreach (mem[i]) mem[i] = 8'hFF;
        progPulses = 0;
        erasePulses = 0;
        seqError = 1'b0;
        busOut = 8'h00;
    end
    assign inRead = (st == M_READ);

    always @(negedge writeStrobeN) begin
        if (!chipSelN) latAddr = locationLines;
    end

    always @(posedge writeStrobeN) begin
        if (!chipSelN && progSupplyHigh && mainSupplyOk) begin
            if (st == M_PROG) begin
                progPulses++;
                progRun++;
                needVerify = 1'b1;
                if (progRun > progResist) mem[pAddr[3:0]] &= pData;
            end
            if (st == M_ERASE) begin
                erasePulses++;
                eraseRun++;
                // one stubborn byte models a slow erase
                foreach (mem[i]) if (i != STUCK || eraseRun > eraseResist) mem[i] = 8'hFF;
            end
            if (st == M_SPROG) begin
                if (needVerify) seqError = 1'b1;
                if (latAddr != pAddr) progRun = 0;
                pAddr = latAddr;
                pData = busIn;
                st = M_PROG;
            end else begin
                case (busIn)
                    8'h40: begin
                        st = M_SPROG;
                        eraseRun = 0;
                    end
                    8'h20: st = (st == M_SERASE) ? M_ERASE : M_SERASE;
                    8'hA0: begin
                        st = M_EVER;
                        vAddr = latAddr;
                    end
                    default: st = M_READ;
                endcase
            end
        end
    end

    always @(negedge progSupplyHigh) begin
        st = M_READ;
    end

    // select and gate move on one edge; look once both have settled
    always @(negedge outGateN) begin
        #1;
        if (!chipSelN) begin
            if (!writeStrobeN) seqError = 1'b1;
            if (identifyHigh && (locationLines & 18'h3FDFE) != 18'h00000) seqError = 1'b1;
            if (!identifyHigh) needVerify = 1'b0;
        end
    end

    always @* begin
        if (identifyHigh) readVal = locationLines[0] ? DEVICE_CODE : MAKER_CODE;
        else if (st == M_EVER) readVal = mem[vAddr[3:0]];
        else readVal = mem[locationLines[3:0]];
    end

    // released lines never hold the last value
    always @(chipSelN or outGateN or readVal) begin
        if (!chipSelN && !outGateN) busOut = readVal;
        else busOut = ~busOut;
    end
endmodule // mtpcs_mem_model

// [verification/tb.sv]
// self-checking bench for the memory host sequencer
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin n_errors++; \
    $display("[FAIL] %s exp %0h got %0h", nm, ex, got); end end
module tb;
    import mtpcs_pkg::*;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic opValid = 1'b0;
    logic opIdSel = 1'b0;
    mtpcs_op_type opKind = MTPCS_OP_READ;
    logic [17:0] opAddr = 18'h00000;
    logic [7:0] opData = 8'h00;
    logic [7:0] progResist = 8'h00;
    logic [7:0] eraseResist = 8'h00;
    logic mainSupplyOk = 1'b1;
    logic [7:0] devBus, lineLevel, opRdata_q, byteLinesOut_q;
    logic [17:0] locationLines_q;
    logic opReady, opDone_q, opFail_q, progSupplyHigh_q, chipSelN_q, outGateN_q;
    logic writeStrobeN_q, byteLinesOe_q, identifyHigh_q, seqError, inRead;
    int progPulses, erasePulses;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;

    assign lineLevel = byteLinesOe_q ? byteLinesOut_q : devBus;

    mtpcs_host #(.PROG_PULSE_CYC(20), .ERASE_PULSE_CYC(50), .LAST_ADDR(18'h0000F)) u_dut (
        .sys_clk(sys_clk), .resetn(resetn), .opValid(opValid), .opKind(opKind), .opAddr(opAddr),
        .opData(opData), .opIdSel(opIdSel), .opReady(opReady), .opDone_q(opDone_q), .opFail_q(opFail_q),
        .opRdata_q(opRdata_q), .progSupplyHigh_q(progSupplyHigh_q), .chipSelN_q(chipSelN_q),
        .outGateN_q(outGateN_q), .writeStrobeN_q(writeStrobeN_q), .locationLines_q(locationLines_q),
        .byteLinesOut_q(byteLinesOut_q), .byteLinesOe_q(byteLinesOe_q), .byteLinesIn(lineLevel),
        .identifyHigh_q(identifyHigh_q));

    mtpcs_mem_model u_mem (
        .chipSelN(chipSelN_q), .outGateN(outGateN_q), .writeStrobeN(writeStrobeN_q),
        .locationLines(locationLines_q), .progSupplyHigh(progSupplyHigh_q), .identifyHigh(identifyHigh_q),
        .mainSupplyOk(mainSupplyOk), .busIn(lineLevel), .progResist(progResist), .eraseResist(eraseResist),
        .busOut(devBus), .progPulses(progPulses), .erasePulses(erasePulses), .seqError(seqError), .inRead(inRead));

    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end

    // whole run needs roughly 8k cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 60000) begin
            n_errors++;
            complete_run();
        end
    end

    task complete_run;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task run_op(input mtpcs_op_type k, input logic [17:0] a, input logic [7:0] d, input logic s);
        int n;
        n = 0;
        while (opReady !== 1'b1 && n < 1000) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        opKind = k;
        opAddr = a;
        opData = d;
        opIdSel = s;
        opValid = 1'b1;
        @(posedge sys_clk);
        #1;
        opValid = 1'b0;
        n = 0;
        while (opDone_q !== 1'b1 && n < 40000) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        `CHK("opDone", 1'b1, opDone_q)
    endtask

    task t_reset;
        `CHK("chipSel", 1'b1, chipSelN_q)
        `CHK("strobe", 1'b1, writeStrobeN_q)
        `CHK("supply", 1'b0, progSupplyHigh_q)
        `CHK("dataOe", 1'b0, byteLinesOe_q)
        `CHK("ready", 1'b1, opReady)
    endtask

    task t_program;
        int p;
        progResist = 8'h03;
        p = progPulses;
        run_op(MTPCS_OP_PROGRAM, 18'h00005, 8'h5A, 1'b0);
        `CHK("progFail", 1'b0, opFail_q)
        `CHK("progPulses", 4, progPulses - p)
        // lower address after higher one
        run_op(MTPCS_OP_PROGRAM, 18'h00003, 8'h3C, 1'b0);
        run_op(MTPCS_OP_READ, 18'h00003, 8'h00, 1'b0);
        `CHK("rd3", 8'h3C, opRdata_q)
        run_op(MTPCS_OP_PROGRAM, 18'h00005, 8'hFF, 1'b0);
        `CHK("progFF", 1'b0, opFail_q)
        run_op(MTPCS_OP_READ, 18'h00005, 8'h00, 1'b0);
        `CHK("rd5", 8'h5A, opRdata_q)
        progResist = 8'h1E;
        p = progPulses;
        run_op(MTPCS_OP_PROGRAM, 18'h00007, 8'h00, 1'b0);
        `CHK("progFail", 1'b1, opFail_q)
        `CHK("progPulses", 25, progPulses - p)
        progResist = 8'h00;
    endtask

    task t_ident;
        run_op(MTPCS_OP_IDENT, 18'h00000, 8'h00, 1'b0);
        `CHK("maker", 8'h01, opRdata_q)
        `CHK("makerParity", 1'b1, ^opRdata_q)
        run_op(MTPCS_OP_IDENT, 18'h00000, 8'h00, 1'b1);
        `CHK("device", 8'h83, opRdata_q)
        `CHK("deviceParity", 1'b1, ^opRdata_q)
    endtask

    task t_erase(input logic [7:0] resist, input logic expFail, input int expPulses);
        int p;
        // a programmed stubborn byte forces re-erase
        run_op(MTPCS_OP_PROGRAM, 18'h00003, 8'h00, 1'b0);
        eraseResist = resist;
        p = erasePulses;
        run_op(MTPCS_OP_ERASE, 18'h00000, 8'h00, 1'b0);
        `CHK("eraseFail", expFail, opFail_q)
        `CHK("erasePulses", expPulses, erasePulses - p)
        if (!expFail) begin
            run_op(MTPCS_OP_READ, 18'h00003, 8'h00, 1'b0);
            `CHK("erased3", 8'hFF, opRdata_q)
        end
    endtask

    task t_abort;
        int p;
        // main supply under lockout: every write ignored, program runs out of pulses
        mainSupplyOk = 1'b0;
        p = progPulses;
        run_op(MTPCS_OP_PROGRAM, 18'h00009, 8'h00, 1'b0);
        `CHK("lowSupplyFail", 1'b1, opFail_q)
        `CHK("lowSupplyPulses", 0, progPulses - p)
        mainSupplyOk = 1'b1;
        run_op(MTPCS_OP_RESET, 18'h00000, 8'h00, 1'b0);
        `CHK("readMode", 1'b1, inRead)
        `CHK("hostSteps", 1'b0, seqError)
    endtask

    initial begin
        repeat (5) @(posedge sys_clk);
        #1;
        resetn = 1'b1;
        t_reset();
        t_program();
        t_ident();
        t_erase(8'h02, 1'b0, 3);
        t_erase(8'h28, 1'b1, 30);
        t_abort();
        complete_run();
    end
endmodule // tb
